// ### rrcff_consts.svh
// Constants of the receive control and frame filter block.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus with byte enables.
`ifndef RRCFF_CONSTS_SVH
`define RRCFF_CONSTS_SVH
`define RRCFF_CLK_MHZ      20
`define RRCFF_TURN_US      192
`define RRCFF_TURN_CYC     (`RRCFF_TURN_US * `RRCFF_CLK_MHZ)
`define RRCFF_TMR_W        12
// Register word offsets (compared with address bits 7:2)
`define RRCFF_A_CMD        6'h00
`define RRCFF_A_MASK_OR    6'h01
`define RRCFF_A_MASK_AND   6'h02
`define RRCFF_A_FILT_A     6'h03
`define RRCFF_A_FILT_B     6'h04
`define RRCFF_A_FSM_CTL    6'h05
`define RRCFF_A_FRM_B      6'h06
`define RRCFF_A_PAN        6'h07
`define RRCFF_A_SHORT      6'h08
`define RRCFF_A_EXT_LO     6'h09
`define RRCFF_A_EXT_HI     6'h0A
`define RRCFF_A_STATUS     6'h0B
// Command strobe bit positions
`define RRCFF_CMD_RXON     0
`define RRCFF_CMD_OFF      1
`define RRCFF_CMD_TXON     2
`define RRCFF_CMD_BSET     3
`define RRCFF_CMD_BCLR     4
// Receiver enable mask bit positions
`define RRCFF_MB_RXON      7
`define RRCFF_MB_TX        6
`define RRCFF_MB_SW        5
// Reset values
`define RRCFF_FILT_A_RST   7'h01
`define RRCFF_FILT_B_RST   7'h0F
`define RRCFF_FSM_CTL_RST  1'b1
`define RRCFF_FRM_B_RST    1'b1
// Frame fields
`define RRCFF_BCAST        16'hFFFF
`define RRCFF_LEN_MIN      7'h09
`define RRCFF_LEN_ACK      7'h05
`define RRCFF_FCS_LEN      7'h02
`define RRCFF_HDR_BYTES    23
`define RRCFF_FT_BEACON    3'h0
`define RRCFF_FT_DATA      3'h1
`define RRCFF_FT_ACK       3'h2
`define RRCFF_FT_CMD       3'h3
`define RRCFF_AM_NONE      2'h0
`define RRCFF_AM_RSV       2'h1
`define RRCFF_AM_SHORT     2'h2
`define RRCFF_AM_EXT       2'h3
`define RRCFF_MOD_INV      2'h1
`define RRCFF_MOD_ZERO     2'h2
`define RRCFF_MOD_ONE      2'h3
`endif

// ### rrcff_pkg.sv
// Types of the receive control and frame filter block.
// Assumes the constants header is compiled alongside.
package rrcff_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CAL, ST_LISTEN, ST_FRAME, ST_GAP, ST_TX
  } rrcff_state_t;

  typedef struct packed {
    logic [2:0] rsv_mask;
    logic [1:0] max_ver;
    logic       coordinator_role;
    logic       filter_on;
  } rrcff_filt_a_t;

  typedef struct packed {
    logic [1:0] type_msb_modifier;
    logic       accept_reserved_types;
    logic       accept_command_frames;
    logic       accept_acknowledgments;
    logic       accept_payload_frames;
    logic       accept_beacons;
  } rrcff_filt_b_t;

  typedef struct packed {
    logic [1:0] src_mode;
    logic [1:0] version;
    logic [1:0] dst_mode;
    logic [2:0] rsv;
    logic       pan_comp;
    logic       ack_req;
    logic       pending;
    logic       security;
    logic [2:0] ftype;
  } rrcff_fcf_t;
endpackage

// ### rrcff_core.sv
// Receiver on/off control and received-frame acceptance filter.
// Assumes demodulator, transmitter and bus all run on clk_i.
`timescale 1ns/1ps
`include "rrcff_consts.svh"

module rrcff_core (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        phy_sfd_i,
  input  wire logic        phy_byte_valid_i,
  input  wire logic [7:0]  phy_byte_i,
  input  wire logic        rx_overflow_i,
  input  wire logic        frame_aborted_event_i,
  input  wire logic        tx_done_i,
  output logic             sfd_search_en_o,
  output logic             rx_ready_o,
  output logic             tx_active_o,
  output logic             abort_o,
  output logic             sfd_status_o,
  output logic             frame_accepted_event_o
);
  localparam logic [`RRCFF_TMR_W-1:0] TURN_LOAD =
    `RRCFF_TMR_W'(`RRCFF_TURN_CYC - 1);

  rrcff_pkg::rrcff_state_t  state;
  rrcff_pkg::rrcff_state_t  next_state;
  rrcff_pkg::rrcff_filt_a_t filter_control_a;
  rrcff_pkg::rrcff_filt_b_t filter_control_b;
  rrcff_pkg::rrcff_fcf_t    fcf;
  logic                     fsm_control;
  logic                     frame_control_b;
  logic [7:0]               receiver_enable_mask;
  logic [7:0]               next_mask;
  logic [15:0]              local_pan;
  logic [15:0]              local_short;
  logic [63:0]              local_ext;
  logic [`RRCFF_TMR_W-1:0]  timer;
  logic [7:0]               hdr [0:`RRCFF_HDR_BYTES-1];
  logic [6:0]               flen;
  logic [6:0]               cnt;
  logic                     len_got;
  logic                     decided;
  logic                     rd_pend;
  logic [31:0]              rd_mux;

  // Bus decode
  wire       wr_cmd   = avs_write_i && avs_address_i[7:2] == `RRCFF_A_CMD && avs_byteenable_i[0];
  wire       wr_or    = avs_write_i && avs_address_i[7:2] == `RRCFF_A_MASK_OR
                        && avs_byteenable_i[0];
  wire       wr_and   = avs_write_i && avs_address_i[7:2] == `RRCFF_A_MASK_AND
                        && avs_byteenable_i[0];
  wire       wr_fa    = avs_write_i && avs_address_i[7:2] == `RRCFF_A_FILT_A
                        && avs_byteenable_i[0];
  wire       wr_fb    = avs_write_i && avs_address_i[7:2] == `RRCFF_A_FILT_B
                        && avs_byteenable_i[0];
  wire       wr_fsm   = avs_write_i && avs_address_i[7:2] == `RRCFF_A_FSM_CTL
                        && avs_byteenable_i[0];
  wire       wr_frm   = avs_write_i && avs_address_i[7:2] == `RRCFF_A_FRM_B
                        && avs_byteenable_i[0];
  wire       wr_pan   = avs_write_i && avs_address_i[7:2] == `RRCFF_A_PAN;
  wire       wr_short = avs_write_i && avs_address_i[7:2] == `RRCFF_A_SHORT;
  wire       wr_elo   = avs_write_i && avs_address_i[7:2] == `RRCFF_A_EXT_LO;
  wire       wr_ehi   = avs_write_i && avs_address_i[7:2] == `RRCFF_A_EXT_HI;
  wire [7:0] wd       = avs_writedata_i[7:0];
  wire       stb_rxon = wr_cmd && wd[`RRCFF_CMD_RXON];
  wire       stb_off  = wr_cmd && wd[`RRCFF_CMD_OFF];
  wire       stb_txon = wr_cmd && wd[`RRCFF_CMD_TXON];
  wire       stb_bset = wr_cmd && wd[`RRCFF_CMD_BSET];
  wire       stb_bclr = wr_cmd && wd[`RRCFF_CMD_BCLR];

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] pan_new   = merge({16'h0000, local_pan}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] short_new = merge({16'h0000, local_short}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] elo_new   = merge(local_ext[31:0], avs_writedata_i, avs_byteenable_i);
  wire [31:0] ehi_new   = merge(local_ext[63:32], avs_writedata_i, avs_byteenable_i);

  // Header field extraction; FCF arrives low byte first
  assign fcf = rrcff_pkg::rrcff_fcf_t'({hdr[1], hdr[0]});
  wire [1:0]  dm      = fcf.dst_mode;
  wire [1:0]  sm      = fcf.src_mode;
  wire        dm_none = dm == `RRCFF_AM_NONE;
  wire        sm_none = sm == `RRCFF_AM_NONE;
  wire [15:0] dpan    = {hdr[4], hdr[3]};
  wire [15:0] dshort  = {hdr[6], hdr[5]};
  logic [63:0] dext;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_dext
      assign dext[8*g +: 8] = hdr[5+g];
    end
  endgenerate

  wire [6:0] dlen = dm == `RRCFF_AM_SHORT ? 7'h02 : dm == `RRCFF_AM_EXT ? 7'h08 : 7'h00;
  wire [6:0] slen = sm == `RRCFF_AM_SHORT ? 7'h02 : sm == `RRCFF_AM_EXT ? 7'h08 : 7'h00;
  wire [6:0] dpan_len = dm_none ? 7'h00 : 7'h02;
  wire       span_in  = !sm_none && !(fcf.pan_comp && !dm_none);
  wire [6:0] span_len = span_in ? 7'h02 : 7'h00;
  wire [6:0] hdr_len  = 7'h03 + dpan_len + dlen + span_len + slen;
  wire [6:0] min_len  = hdr_len + `RRCFF_FCS_LEN;
  // Compressed source PAN is the destination PAN
  wire [15:0] span_val = !span_in ? dpan :
                         dm == `RRCFF_AM_SHORT ? {hdr[8], hdr[7]} :
                         dm == `RRCFF_AM_EXT ? {hdr[14], hdr[13]} : {hdr[4], hdr[3]};

  // Type MSB modifier only changes the filter's view of the type
  wire [1:0] tmod  = filter_control_b.type_msb_modifier;
  wire       t_msb = tmod == `RRCFF_MOD_INV  ? !fcf.ftype[2] :
                     tmod == `RRCFF_MOD_ZERO ? 1'b0 :
                     tmod == `RRCFF_MOD_ONE  ? 1'b1 : fcf.ftype[2];
  wire [2:0] ftype = {t_msb, fcf.ftype[1:0]};

  // Settings are read live, so a mid-frame change may or may not count
  wire len_ok   = flen >= min_len;
  wire rsv_ok   = (fcf.rsv & filter_control_a.rsv_mask) == 3'h0;
  wire ver_ok   = fcf.version <= filter_control_a.max_ver;
  wire mode_ok  = dm != `RRCFF_AM_RSV && sm != `RRCFF_AM_RSV;
  wire dpan_ok  = dm_none || dpan == local_pan || dpan == `RRCFF_BCAST;
  wire daddr_ok = dm_none ||
                  (dm == `RRCFF_AM_SHORT &&
                   (dshort == local_short || dshort == `RRCFF_BCAST)) ||
                  (dm == `RRCFF_AM_EXT && dext == local_ext);
  wire span_eq  = span_val == local_pan;
  wire long_ok  = flen >= `RRCFF_LEN_MIN;
  wire bcn_ok   = filter_control_b.accept_beacons && long_ok && dm_none &&
                  (sm == `RRCFF_AM_SHORT || sm == `RRCFF_AM_EXT) &&
                  (span_eq || local_pan == `RRCFF_BCAST);
  wire addr_ok  = (!dm_none || !sm_none) &&
                  (!dm_none || (filter_control_a.coordinator_role && span_eq));
  wire data_ok  = filter_control_b.accept_payload_frames && long_ok && addr_ok;
  wire cmd_ok   = filter_control_b.accept_command_frames && long_ok && addr_ok;
  wire ack_ok   = filter_control_b.accept_acknowledgments &&
                  flen == `RRCFF_LEN_ACK;
  wire rtyp_ok  = filter_control_b.accept_reserved_types && long_ok;
  wire type_ok  = ftype == `RRCFF_FT_BEACON ? bcn_ok :
                  ftype == `RRCFF_FT_DATA   ? data_ok :
                  ftype == `RRCFF_FT_ACK    ? ack_ok :
                  ftype == `RRCFF_FT_CMD    ? cmd_ok : rtyp_ok;
  wire pass     = len_ok && rsv_ok && ver_ok && mode_ok && dpan_ok && daddr_ok && type_ok;

  // Frame progress
  wire in_frame  = state == rrcff_pkg::ST_FRAME;
  wire byte_in   = in_frame && phy_byte_valid_i;
  wire hdr_done  = len_got && (cnt == flen || (cnt >= 7'h03 && cnt == hdr_len));
  wire killed    = in_frame && (rx_overflow_i || frame_aborted_event_i);
  wire decide    = in_frame && !decided && !killed &&
                   (hdr_done || (len_got && !filter_control_a.filter_on));
  wire accept_ev = decide && filter_control_a.filter_on && pass;
  wire reject    = decide && filter_control_a.filter_on && !pass;
  wire frame_end = in_frame && (killed || (len_got && cnt == flen));

  // Receiver enable mask
  always_comb begin
    next_mask = receiver_enable_mask;
    if (wr_or) begin
      next_mask = next_mask | wd;
    end
    if (wr_and) begin
      next_mask = next_mask & wd;
    end
    if (stb_bset) begin
      next_mask[`RRCFF_MB_SW] = 1'b1;
    end
    if (stb_bclr) begin
      next_mask[`RRCFF_MB_SW] = 1'b0;
    end
    if (stb_txon && frame_control_b) begin
      next_mask[`RRCFF_MB_TX] = 1'b1;
    end
    if (stb_rxon) begin
      next_mask[`RRCFF_MB_RXON] = 1'b1;
    end
    if (stb_off) begin
      next_mask = 8'h00;
    end
  end

  wire mask_on  = next_mask != 8'h00;
  wire tmr_done = timer == `RRCFF_TMR_W'(0);

  // Radio state; hard strobes override any activity
  always_comb begin
    next_state = state;
    unique case (state)
      rrcff_pkg::ST_IDLE: begin
        if (mask_on) begin
          next_state = rrcff_pkg::ST_CAL;
        end
      end
      rrcff_pkg::ST_CAL: begin
        if (!mask_on) begin
          next_state = rrcff_pkg::ST_IDLE;
        end else if (tmr_done) begin
          next_state = rrcff_pkg::ST_LISTEN;
        end
      end
      rrcff_pkg::ST_LISTEN: begin
        if (!mask_on) begin
          next_state = rrcff_pkg::ST_IDLE;
        end else if (phy_sfd_i) begin
          next_state = rrcff_pkg::ST_FRAME;
        end
      end
      rrcff_pkg::ST_FRAME: begin
        if (frame_end) begin
          next_state = !mask_on ? rrcff_pkg::ST_IDLE :
                       fsm_control ? rrcff_pkg::ST_GAP :
                       rrcff_pkg::ST_LISTEN;
        end
      end
      rrcff_pkg::ST_GAP: begin
        if (!mask_on) begin
          next_state = rrcff_pkg::ST_IDLE;
        end else if (tmr_done) begin
          next_state = rrcff_pkg::ST_LISTEN;
        end
      end
      rrcff_pkg::ST_TX: begin
        if (tx_done_i) begin
          next_state = mask_on ? rrcff_pkg::ST_CAL : rrcff_pkg::ST_IDLE;
        end
      end
    endcase
    if (stb_txon && state != rrcff_pkg::ST_TX) begin
      next_state = rrcff_pkg::ST_TX;
    end
    if (stb_rxon) begin
      next_state = rrcff_pkg::ST_CAL;
    end
    if (stb_off) begin
      next_state = rrcff_pkg::ST_IDLE;
    end
  end

  // Reload on entry, and again on receive-on inside calibration
  wire tmr_load = (next_state == rrcff_pkg::ST_CAL || next_state == rrcff_pkg::ST_GAP) &&
                  (next_state != state || stb_rxon);
  wire hard_abort = (stb_rxon || stb_off) &&
                    (state == rrcff_pkg::ST_TX || in_frame);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state                <= rrcff_pkg::ST_IDLE;
      receiver_enable_mask <= 8'h00;
      timer                <= `RRCFF_TMR_W'(0);
      abort_o              <= 1'b0;
    end else begin
      state                <= next_state;
      receiver_enable_mask <= next_mask;
      timer                <= tmr_load ? TURN_LOAD : tmr_done ? timer : timer - 1'b1;
      abort_o              <= hard_abort;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filter_control_a <= `RRCFF_FILT_A_RST;
      filter_control_b <= `RRCFF_FILT_B_RST;
      fsm_control      <= `RRCFF_FSM_CTL_RST;
      frame_control_b  <= `RRCFF_FRM_B_RST;
      local_pan        <= 16'h0000;
      local_short      <= 16'h0000;
      local_ext        <= 64'h0000000000000000;
    end else begin
      if (wr_fa) begin
        filter_control_a <= wd[6:0];
      end
      if (wr_fb) begin
        filter_control_b <= wd[6:0];
      end
      if (wr_fsm) begin
        fsm_control <= wd[0];
      end
      if (wr_frm) begin
        frame_control_b <= wd[0];
      end
      if (wr_pan) begin
        local_pan <= pan_new[15:0];
      end
      if (wr_short) begin
        local_short <= short_new[15:0];
      end
      if (wr_elo) begin
        local_ext[31:0] <= elo_new;
      end
      if (wr_ehi) begin
        local_ext[63:32] <= ehi_new;
      end
    end
  end

  // Frame capture; header bytes kept, stored frame data untouched
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flen    <= 7'h00;
      cnt     <= 7'h00;
      len_got <= 1'b0;
      decided <= 1'b0;
    end else if (!in_frame) begin
      cnt     <= 7'h00;
      len_got <= 1'b0;
      decided <= 1'b0;
    end else begin
      if (decide || killed) begin
        decided <= 1'b1;
      end
      if (byte_in && !len_got) begin
        flen    <= phy_byte_i[6:0];
        len_got <= 1'b1;
      end else if (byte_in && cnt != flen) begin
        cnt <= cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (byte_in && len_got && cnt < 7'(`RRCFF_HDR_BYTES)) begin
      hdr[cnt[4:0]] <= phy_byte_i;
    end
  end

  // Start-of-frame status and accept event
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfd_status_o           <= 1'b0;
      frame_accepted_event_o <= 1'b0;
    end else begin
      frame_accepted_event_o <= accept_ev;
      if (state == rrcff_pkg::ST_LISTEN && next_state == rrcff_pkg::ST_FRAME) begin
        sfd_status_o <= 1'b1;
      end else if (frame_end || reject || !in_frame) begin
        sfd_status_o <= 1'b0;
      end
    end
  end

  // Register read path, one wait cycle per read
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (avs_address_i[7:2])
      `RRCFF_A_MASK_OR,
      `RRCFF_A_MASK_AND: rd_mux = {24'h000000, receiver_enable_mask};
      `RRCFF_A_FILT_A:   rd_mux = {25'h0000000, filter_control_a};
      `RRCFF_A_FILT_B:   rd_mux = {25'h0000000, filter_control_b};
      `RRCFF_A_FSM_CTL:  rd_mux = {31'h00000000, fsm_control};
      `RRCFF_A_FRM_B:    rd_mux = {31'h00000000, frame_control_b};
      `RRCFF_A_PAN:      rd_mux = {16'h0000, local_pan};
      `RRCFF_A_SHORT:    rd_mux = {16'h0000, local_short};
      `RRCFF_A_EXT_LO:   rd_mux = local_ext[31:0];
      `RRCFF_A_EXT_HI:   rd_mux = local_ext[63:32];
      `RRCFF_A_STATUS:   rd_mux = {28'h0000000, rx_ready_o, tx_active_o,
                                   sfd_search_en_o, sfd_status_o};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_pend        <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      rd_pend <= avs_read_i && !rd_pend;
      if (avs_read_i && !rd_pend) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  assign avs_waitrequest_o = avs_read_i && !rd_pend;
  assign sfd_search_en_o   = state == rrcff_pkg::ST_LISTEN;
  assign rx_ready_o        = state == rrcff_pkg::ST_LISTEN || in_frame ||
                             state == rrcff_pkg::ST_GAP;
  assign tx_active_o       = state == rrcff_pkg::ST_TX;
endmodule // rrcff_core

// ### rrcff_air.sv
// Air-side sender model: start-of-frame pulse, then length and MPDU bytes.
// Assumes the bench calls send only while the receiver searches.
`timescale 1ns/1ps
module rrcff_air (
  input  wire logic       clk_i,
  output logic            phy_sfd_o,
  output logic            phy_byte_valid_o,
  output logic [7:0]      phy_byte_o
);
  initial begin
    phy_sfd_o = 1'b0;
    phy_byte_valid_o = 1'b0;
    phy_byte_o = 8'h00;
  end
  task automatic send(input logic [79:0] f);
    int n;
    @(posedge clk_i);
    phy_sfd_o <= 1'b1;
    @(posedge clk_i);
    phy_sfd_o <= 1'b0;
    for (n = 0; n <= int'(f[78:72]); n++) begin  // Whole frame even if rejected
      repeat (3) @(posedge clk_i);
      phy_byte_valid_o <= 1'b1;
      phy_byte_o <= f[79 - 8 * n -: 8];
      @(posedge clk_i);
      phy_byte_valid_o <= 1'b0;
      // Stale byte must not look valid
      phy_byte_o <= ~f[79 - 8 * n -: 8];
    end
  endtask
endmodule  // rrcff_air

// ### rrcff_asserts.sv
// Port checks of the receive control and frame filter block.
// Assumes binding onto rrcff_core with a 20 MHz clk_i.
`timescale 1ns/1ps
module rrcff_asserts (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        phy_sfd_i,
  input wire logic        sfd_search_en_o,
  input wire logic        rx_ready_o,
  input wire logic        tx_active_o,
  input wire logic        abort_o,
  input wire logic        sfd_status_o,
  input wire logic        frame_accepted_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [12:0] idle_cnt;
  wire         cmd_wr = avs_write_i && avs_address_i[7:2] == 6'h00;
  wire         and_wr = avs_write_i && avs_address_i[7:2] == 6'h02;
  // Saturates so a long idle spell cannot wrap
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) idle_cnt <= 13'h0000;
    else if (rx_ready_o) idle_cnt <= 13'h0000;
    else if (!(&idle_cnt)) idle_cnt <= idle_cnt + 13'h0001;
  a_turn_time: assert property ($rose(rx_ready_o) |-> idle_cnt >= 13'hEFF)
    else $error("receiver ready too early");
  a_rx_on_cal: assert property (cmd_wr && avs_writedata_i[0] |=> !rx_ready_o)
    else $error("receive-on did not restart calibration");
  a_off_idle: assert property (cmd_wr && avs_writedata_i[1] |=> !rx_ready_o && !tx_active_o)
    else $error("radio-off did not force idle");
  a_and_idle: assert property (sfd_search_en_o && and_wr && avs_writedata_i[7:0] == 8'h00
    |-> ##2 !rx_ready_o) else $error("cleared mask left receiver on");
  a_and_no_abort: assert property (and_wr |=> !abort_o)
    else $error("mask port write aborted activity");
  a_abort_cause: assert property (abort_o |-> $past(cmd_wr) && $past(avs_writedata_i[1:0]) != 2'h0)
    else $error("abort without strobe");
  a_sfd_rise: assert property ($rose(sfd_status_o) |-> $past(phy_sfd_i) && $past(sfd_search_en_o))
    else $error("start status without delimiter");
  a_accept_pulse: assert property (frame_accepted_event_o |=> !frame_accepted_event_o)
    else $error("accept event longer than one cycle");
  a_accept_frame: assert property (frame_accepted_event_o |-> $past(sfd_status_o))
    else $error("accept event outside a frame");
  a_search_quiet: assert property (sfd_search_en_o |-> rx_ready_o && !sfd_status_o)
    else $error("searching during a frame");
endmodule  // rrcff_asserts
bind rrcff_core rrcff_asserts rrcff_asserts_i (.clk_i, .rstn_i, .avs_address_i, .avs_write_i,
  .avs_writedata_i, .phy_sfd_i, .sfd_search_en_o, .rx_ready_o, .tx_active_o, .abort_o,
  .sfd_status_o, .frame_accepted_event_o);

// ### rrcff_tb_top.sv
// Bench of the receive control and frame filter block.
// Assumes core, air model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); \
  end \
end
module rrcff_tb_top;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd_q = 1'b0;
  logic        wr_q = 1'b0;
  logic        tx_done = 1'b0;
  logic        ovf = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [7:0]  q;
  logic [7:0]  pb;
  logic        wait_o, sfd, bv, srch, rdy, txa, sst, acc;
  int          bad_count = 0;
  int          check_count = 0;
  int          acc_count = 0;
  logic [79:0] fr [11] = '{
    80'h8502_0011_AABB_0000_0000,  // Ack, length bit 7 set
    80'h0602_0011_AABB_CC00_0000,  // Ack of wrong length
    80'h0901_0822_3412_7856_AABB,  // Data to local short
    80'h0901_0822_3412_7956_AABB,  // Data to foreign short
    80'h0901_0823_FFFF_FFFF_AABB,  // Broadcast PAN and short
    80'h0901_0823_3512_7856_AABB,  // Foreign PAN
    80'h0900_8024_3412_0100_AABB,  // Beacon
    80'h0904_0822_3412_7856_AABB,  // Reserved type
    80'h0901_0422_3412_7856_AABB,  // Reserved address mode
    80'h0801_0822_3412_7856_AA00,  // Too short
    80'h0981_0822_3412_7856_AABB   // Reserved bit under zero mask
  };
  logic [10:0] ea = 11'h455;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (acc === 1'b1) acc_count++;
  rrcff_core rrcff_core_i (.clk_i, .rstn_i, .avs_address_i(adr), .avs_read_i(rd_q),
    .avs_write_i(wr_q), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .phy_sfd_i(sfd),
    .phy_byte_valid_i(bv), .phy_byte_i(pb), .rx_overflow_i(ovf),
    .frame_aborted_event_i(1'b0), .tx_done_i(tx_done), .sfd_search_en_o(srch),
    .rx_ready_o(rdy), .tx_active_o(txa), .abort_o(), .sfd_status_o(sst),
    .frame_accepted_event_o(acc));
  rrcff_air rrcff_air_i (.clk_i, .phy_sfd_o(sfd), .phy_byte_valid_o(bv), .phy_byte_o(pb));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic fail();
    bad_count++;
    conclude();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    wr_q <= w;
    rd_q <= !w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 9; n++) begin
      @(posedge clk_i);
      if (wait_o === 1'b0) break;
    end
    q = rdat[7:0];
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    @(posedge clk_i);
    if (n == 9) fail();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("register", e, q)
  endtask
  task automatic wsrch(output int n);
    for (n = 0; n < 5000 && srch !== 1'b1; n++)
      @(posedge clk_i);
    if (n == 5000) fail();
  endtask
  task automatic frame(input logic [79:0] f, input logic e);
    int c;
    int n;
    wsrch(n);
    c = acc_count;
    rrcff_air_i.send(f);
    repeat (6) @(posedge clk_i);
    `CHK("accept", e, acc_count != c)
  endtask
  initial begin
    int n;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(8'h0C, 8'h01);
    rd(8'h10, 8'h0F);
    rd(8'h14, 8'h01);
    rd(8'h18, 8'h01);
    rd(8'h3C, 8'h00);
    bus(1'b1, 8'h1C, 32'h0000_1234);
    bus(1'b1, 8'h20, 32'h0000_5678);
    bus(1'b1, 8'h00, 32'h0000_0001);
    rd(8'h04, 8'h80);
    wsrch(n);
    `CHK("turnaround", 1'b1, n > 3820 && n < 3845)
    rd(8'h2C, 8'h0A);
    for (int i = 0; i < 11; i++) begin
      frame(fr[i], ea[i]);
      if (i == 0) `CHK("gap", 1'b0, srch)
    end
    bus(1'b1, 8'h0C, 32'h0000_0071);
    frame(fr[10], 1'b0);
    // Overflow well before the header is complete must silence the event
    wsrch(n);
    n = acc_count;
    fork
      rrcff_air_i.send(fr[2]);
      begin
        repeat (12) @(posedge clk_i);
        ovf <= 1'b1;
        @(posedge clk_i);
        ovf <= 1'b0;
        @(posedge clk_i);
        `CHK("killed status", 1'b0, sst)
      end
    join
    repeat (6) @(posedge clk_i);
    `CHK("killed accept", 1'b0, acc_count != n)
    bus(1'b1, 8'h0C, 32'h0000_0001);
    bus(1'b1, 8'h14, 32'h0000_0000);
    frame(fr[2], 1'b1);
    `CHK("no gap", 1'b1, srch)
    bus(1'b1, 8'h10, 32'h0000_002F);
    frame(fr[0], 1'b0);
    bus(1'b1, 8'h0C, 32'h0000_0000);
    frame(fr[2], 1'b0);
    bus(1'b1, 8'h08, 32'h0000_0000);
    rd(8'h04, 8'h00);
    `CHK("ready", 1'b0, rdy)
    bus(1'b1, 8'h04, 32'h0000_0001);
    rd(8'h04, 8'h01);
    wsrch(n);
    bus(1'b1, 8'h00, 32'h0000_0004);
    rd(8'h04, 8'h41);
    `CHK("tx", 1'b1, txa)
    bus(1'b1, 8'h00, 32'h0000_0002);
    rd(8'h04, 8'h00);
    `CHK("off", 1'b0, txa | rdy)
    bus(1'b1, 8'h00, 32'h0000_0004);
    tx_done <= 1'b1;
    @(posedge clk_i);
    tx_done <= 1'b0;
    wsrch(n);
    conclude();
  end
endmodule  // rrcff_tb_top
